// ### rtl/hmp_ports.sv
// Purpose: three host mailbox ports between a host bus and the controller
// Assumes: host pins are asynchronous and pass two flip-flops
// Notes: data, output, command and user status bits are never reset
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [R01] one low select picks a port; none or several low is ignored
// [R02] host read gives output data at address 0, status at address 1
// [R03] host write loads input data; command flag follows address bit
// [R04] each port has input, output and status registers on both sides
// [R05] input data is host write-only; controller writes are ignored
// [R06] a host write sets that port's input-full flag
// [R07] input-full with its enable raises a controller interrupt
// [R08] input data registers are untouched by reset
// [R09] status: bit3 command, bit1 input full, bit0 output full, rest user
// [R10] five user status bits: controller read/write, host read-only
// [R11] reset clears only status bits 1 and 0
// [R12] controller map at the fixed special register addresses
// [R13] controller read of input data clears input-full
// [R14] controller write sets output-full; host read of output clears it
// [R15] output-full drives host interrupt: high for keyboard, low others
// [R16] command flags change only on host writes
// [R17] controller status writes touch only user bits
module hmp_ports (
   input wire logic clk,
   input wire logic resetn,
   input wire logic kbd_port_select_n,
   input wire logic power_port_one_select_n,
   input wire logic power_port_two_select_n,
   input wire logic host_addr_bit,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr_en,
   input wire logic sfr_rd_en,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic kbd_in_irq_enable,
   input wire logic power_one_in_irq_enable,
   input wire logic power_two_in_irq_enable,
   output logic kbd_in_irq,
   output logic power_one_in_irq,
   output logic power_two_in_irq,
   output logic kbd_host_irq,
   output logic power_one_host_irq_n,
   output logic power_two_host_irq_n
);
   localparam int N = hmp_pkg::NPORTS;
   localparam int DW = hmp_pkg::DW;

   logic rst_m_q, rst_n_q;
   logic [13:0] sync1_q, sync2_q;
   logic [2:0] sel_n_s;
   logic addr_s, rd_a, wr_a;
   logic [DW-1:0] data_s;
   logic [1:0] port_s;

   // host cycle state
   hmp_pkg::hmp_host_st_t st_q, st_d;
   logic [1:0] port_q, port_d;
   logic addr_q, addr_d;
   logic [DW-1:0] wdat_q, wdat_d, hout_q, hout_d;
   logic oe_q, oe_d, pend_q, pend_d;
   logic [hmp_pkg::BW-1:0] pdat_q, pdat_d;
   logic rd_done;

   // flags and storage
   logic [N-1:0] ibf_q, ibf_d, obf_q, obf_d, cmd_q, cmd_d;
   logic [N-1:0] hit_st, hit_in, hit_out, drain_p, en;
   logic [N-1:0] iirq_q, iirq_d;
   logic [DW-1:0] din_q [N];
   logic [DW-1:0] din_d [N];
   logic [DW-1:0] dout_q [N];
   logic [DW-1:0] dout_d [N];
   logic [4:0] user_q [N];
   logic [4:0] user_d [N];
   logic [DW-1:0] stat [N];
   logic [DW-1:0] rdat_q, rdat_d;
   logic drain;

   hmp_xfer_if #(.W(hmp_pkg::BW)) fill_x ();
   hmp_xfer_if #(.W(hmp_pkg::BW)) drain_x ();

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sync1_q <= hmp_pkg::SYNC_RESET;
         sync2_q <= hmp_pkg::SYNC_RESET;
      end else begin
         sync1_q <= {host_data_in, host_write_strobe_n, host_read_strobe_n,
                     host_addr_bit, power_port_two_select_n,
                     power_port_one_select_n, kbd_port_select_n};
         sync2_q <= sync1_q;
      end
   end

   assign sel_n_s = sync2_q[2:0];
   assign addr_s = sync2_q[3];
   assign rd_a = !sync2_q[4];
   assign wr_a = !sync2_q[5];
   assign data_s = sync2_q[13:6];

   always_comb begin
      case (sel_n_s) // [R01]
         3'b110: port_s = 2'h0;
         3'b101: port_s = 2'h1;
         3'b011: port_s = 2'h2;
         default: port_s = hmp_pkg::PORT_NONE;
      endcase
   end

   // per-port register decode and status image
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gp
         assign hit_st[g] = (sfr_addr == hmp_pkg::STATUS_OFS[g]); // [R12]
         assign hit_in[g] = (sfr_addr == hmp_pkg::INPUT_OFS[g]); // [R04]
         assign hit_out[g] = (sfr_addr == hmp_pkg::OUTPUT_OFS[g]);
         assign drain_p[g] = drain && (drain_x.data[10:9] == 2'(g));
         assign stat[g] = {user_q[g][4:1], cmd_q[g], user_q[g][0],
                           ibf_q[g], obf_q[g]}; // [R09]
      end
   endgenerate
   assign en = {power_two_in_irq_enable, power_one_in_irq_enable,
                kbd_in_irq_enable};

   always_comb begin
      st_d = st_q;
      port_d = port_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      hout_d = hout_q;
      oe_d = oe_q;
      pend_d = pend_q && !fill_x.ready;
      pdat_d = pdat_q;
      rd_done = 1'b0;
      case (st_q)
         hmp_pkg::HST_IDLE: begin
            if (rd_a && port_s != hmp_pkg::PORT_NONE) begin
               st_d = hmp_pkg::HST_READ;
               port_d = port_s;
               addr_d = addr_s;
               oe_d = 1'b1;
               hout_d = addr_s ? stat[port_s] : dout_q[port_s]; // [R02]
            end else if (wr_a && port_s != hmp_pkg::PORT_NONE) begin
               st_d = hmp_pkg::HST_WRITE;
               port_d = port_s;
               addr_d = addr_s;
               wdat_d = data_s;
            end
         end
         hmp_pkg::HST_READ: begin
            if (!rd_a) begin
               st_d = hmp_pkg::HST_IDLE;
               oe_d = 1'b0;
               rd_done = !addr_q;
            end
         end
         hmp_pkg::HST_WRITE: begin
            if (wr_a) begin
               wdat_d = data_s;
            end else if (!pend_d) begin
               // a full buffer holds the cycle here until space frees
               st_d = hmp_pkg::HST_IDLE;
               pend_d = 1'b1;
               pdat_d = {port_q, addr_q, wdat_q}; // [R03]
            end
         end
         default: begin
            st_d = hmp_pkg::HST_IDLE;
            oe_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= hmp_pkg::HST_IDLE;
         port_q <= hmp_pkg::PORT_NONE;
         addr_q <= 1'b0;
         wdat_q <= '0;
         hout_q <= '0;
         oe_q <= 1'b0;
         pend_q <= 1'b0;
         pdat_q <= '0;
      end else begin
         st_q <= st_d;
         port_q <= port_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         hout_q <= hout_d;
         oe_q <= oe_d;
         pend_q <= pend_d;
         pdat_q <= pdat_d;
      end
   end

   assign fill_x.valid = pend_q;
   assign fill_x.data = pdat_q;

   hmp_buf #(.W(hmp_pkg::BW), .DEPTH(hmp_pkg::BUF_DEPTH)) u_buf (
      .clk(clk),
      .rst_n(rst_n_q),
      .in_x(fill_x),
      .out_x(drain_x)
   );

   // hold a write back while the controller reads an input register
   assign drain_x.ready = !(sfr_rd_en && |hit_in);
   assign drain = drain_x.valid && drain_x.ready;

   always_comb begin
      ibf_d = ibf_q;
      obf_d = obf_q;
      cmd_d = cmd_q;
      din_d = din_q;
      dout_d = dout_q;
      user_d = user_q;
      rdat_d = rdat_q;
      for (int i = 0; i < N; i++) begin
         if (sfr_rd_en && hit_in[i]) begin
            ibf_d[i] = 1'b0; // [R13]
         end
         if (drain_p[i]) begin
            din_d[i] = drain_x.data[7:0];
            cmd_d[i] = drain_x.data[8]; // [R03] [R16]
            ibf_d[i] = 1'b1; // [R06]
         end
         if (rd_done && port_q == 2'(i)) begin
            obf_d[i] = 1'b0;
         end
         if (sfr_wr_en && hit_out[i]) begin
            dout_d[i] = sfr_wdata;
            obf_d[i] = 1'b1; // [R14]
         end
         if (sfr_wr_en && hit_st[i]) begin
            user_d[i] = {sfr_wdata[7:hmp_pkg::USER_HI_LSB],
                         sfr_wdata[hmp_pkg::USER_LO_BIT]}; // [R10] [R17]
         end
         if (sfr_rd_en && hit_st[i]) begin
            rdat_d = stat[i];
         end
         if (sfr_rd_en && hit_in[i]) begin
            rdat_d = din_q[i]; // [R05]
         end
         if (sfr_rd_en && hit_out[i]) begin
            rdat_d = dout_q[i];
         end
      end
      iirq_d = ibf_d & en; // [R07]
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ibf_q <= {N{hmp_pkg::FLAG_RESET}}; // [R11]
         obf_q <= {N{hmp_pkg::FLAG_RESET}};
         iirq_q <= '0;
         rdat_q <= '0;
      end else begin
         ibf_q <= ibf_d;
         obf_q <= obf_d;
         iirq_q <= iirq_d;
         rdat_q <= rdat_d;
      end
   end

   // kept through reset
   always_ff @(posedge clk) begin
      din_q <= din_d; // [R08]
      dout_q <= dout_d;
      cmd_q <= cmd_d; // [R11]
      user_q <= user_d;
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         kbd_host_irq <= 1'b0;
         power_one_host_irq_n <= 1'b1;
         power_two_host_irq_n <= 1'b1;
      end else begin
         kbd_host_irq <= obf_d[0]; // [R15]
         power_one_host_irq_n <= !obf_d[1];
         power_two_host_irq_n <= !obf_d[2];
      end
   end

   assign host_data_out = hout_q;
   assign host_data_oe = oe_q;
   assign sfr_rdata = rdat_q;
   assign kbd_in_irq = iirq_q[0];
   assign power_one_in_irq = iirq_q[1];
   assign power_two_in_irq = iirq_q[2];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_q);

   chk_oe_read_only: assert property ( // [R01]
      host_data_oe |-> st_q == hmp_pkg::HST_READ)
      else $error("data driven outside a host read");
   chk_read_out_mux: assert property ( // [R02]
      st_q == hmp_pkg::HST_IDLE && rd_a && port_s == 2'h0 && !addr_s
      |=> host_data_out == $past(dout_q[0]) && host_data_oe)
      else $error("host read returned wrong register");
   chk_cmd_from_addr: assert property ( // [R03]
      drain_p[1] |=> cmd_q[1] == $past(drain_x.data[8]))
      else $error("command flag does not follow address");
   chk_din_write_ro: assert property ( // [R05]
      sfr_wr_en && hit_in[0] && !drain_p[0] |=> $stable(din_q[0]))
      else $error("controller changed input data");
   chk_ibf_set_drain: assert property ( // [R06]
      drain_p[2] |=> ibf_q[2])
      else $error("input full not set by host write");
   chk_in_irq_gate: assert property ( // [R07]
      ibf_q[0] && $past(kbd_in_irq_enable) |-> kbd_in_irq)
      else $error("controller interrupt missing");
   chk_ibf_clear_read: assert property ( // [R13]
      sfr_rd_en && hit_in[1] && !drain_p[1] |=> !ibf_q[1])
      else $error("input full not cleared by read");
   chk_obf_set_write: assert property ( // [R14]
      sfr_wr_en && hit_out[0] |=> obf_q[0] [*1] ##0 kbd_host_irq)
      else $error("output full not set");
   chk_host_irq_levels: assert property ( // [R15]
      kbd_host_irq == obf_q[0] && power_one_host_irq_n == !obf_q[1]
      && power_two_host_irq_n == !obf_q[2])
      else $error("host interrupt level mismatch");
   chk_cmd_host_only: assert property ( // [R16]
      cmd_q[0] != $past(cmd_q[0]) |-> $past(drain_p[0]))
      else $error("command flag changed without host write");
   chk_status_user_wr: assert property ( // [R17]
      sfr_wr_en && hit_st[2] && !drain_p[2] && !sfr_rd_en
      |=> $stable(ibf_q[2]) && $stable(cmd_q[2]))
      else $error("status write touched hardware flags");

   cov_host_write: cover property (drain_p[0] ##[1:20] ibf_q[0]);
   cov_host_read_out: cover property (rd_done ##1 !obf_q[port_q]);
   cov_buf_stall: cover property (pend_q && !fill_x.ready);
endmodule
`default_nettype wire

// ### rtl/hmp_pkg.sv
// Purpose: shared constants and types of the host mailbox ports
// Assumes: three identical byte-wide ports
// Notes: offsets are controller register addresses
`default_nettype none
package hmp_pkg;
   localparam int NPORTS = 3;
   localparam int DW = 8;
   // bundle: {port index, command flag, data}
   localparam int BW = 11;
   localparam int BUF_DEPTH = 2;
   localparam logic [7:0] KBD_STATUS_OFS = 8'had;
   localparam logic [7:0] KBD_INPUT_OFS = 8'hae;
   localparam logic [7:0] KBD_OUTPUT_OFS = 8'haf;
   localparam logic [7:0] PWR1_STATUS_OFS = 8'hbd;
   localparam logic [7:0] PWR1_INPUT_OFS = 8'hbe;
   localparam logic [7:0] PWR1_OUTPUT_OFS = 8'hbf;
   localparam logic [7:0] PWR2_STATUS_OFS = 8'hf5;
   localparam logic [7:0] PWR2_INPUT_OFS = 8'hf6;
   localparam logic [7:0] PWR2_OUTPUT_OFS = 8'hf7;
   localparam logic [7:0] STATUS_OFS [NPORTS] =
      '{KBD_STATUS_OFS, PWR1_STATUS_OFS, PWR2_STATUS_OFS};
   localparam logic [7:0] INPUT_OFS [NPORTS] =
      '{KBD_INPUT_OFS, PWR1_INPUT_OFS, PWR2_INPUT_OFS};
   localparam logic [7:0] OUTPUT_OFS [NPORTS] =
      '{KBD_OUTPUT_OFS, PWR1_OUTPUT_OFS, PWR2_OUTPUT_OFS};
   // status register fields
   localparam int OBF_BIT = 0;
   localparam int IBF_BIT = 1;
   localparam int USER_LO_BIT = 2;
   localparam int CMD_BIT = 3;
   localparam int USER_HI_LSB = 4;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic [1:0] PORT_NONE = 2'h3;
   // synced pins: {data, write_n, read_n, addr, select_n[2:0]}
   localparam logic [13:0] SYNC_RESET = 14'h0037;
   typedef enum logic [2:0] {
      HST_IDLE = 3'h1,
      HST_READ = 3'h2,
      HST_WRITE = 3'h4
   } hmp_host_st_t;
endpackage
`default_nettype wire

// ### rtl/hmp_xfer_if.sv
// Purpose: valid/ready carrier for buffered host writes
// Assumes: one source and one sink on the same clock
// Notes: data is held by the source while valid and not ready
`timescale 1ns/10ps
`default_nettype none
interface hmp_xfer_if #(parameter int W = 11) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/hmp_buf.sv
// Purpose: small fifo between host write capture and the mailboxes
// Assumes: single clock, synchronous pointers
// Notes: ready and valid come from registered occupancy
`timescale 1ns/10ps
`default_nettype none
module hmp_buf #(
   parameter int W = 11,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   hmp_xfer_if.snk in_x,
   hmp_xfer_if.src out_x
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_x.ready = (cnt_q != FULL);
   assign out_x.valid = (cnt_q != '0);
   assign out_x.data = mem_q[rptr_q];
   assign push = in_x.valid && in_x.ready;
   assign pop = out_x.valid && out_x.ready;

   always_comb begin
      mem_d = mem_q;
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wptr_q] = in_x.data;
         wptr_d = (wptr_q == LAST) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
         rptr_d = (rptr_q == LAST) ? '0 : rptr_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q <= cnt_d;
      end
   end

   chk_buf_bound: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_q <= FULL) else $error("buffer count overflow");
endmodule
`default_nettype wire

// ### testbench/hmp_host_model.sv
// Purpose: host cpu side of the mailbox ports, one bus cycle per call
// Assumes: strobes held low 7 clocks and high at least 13 clocks
// Notes: a released data bus shows a pattern that flips every clock
`timescale 1ns/10ps
`default_nettype none
module hmp_host_model (
   input wire logic clk,
   output logic [2:0] sel_n,
   output logic addr,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] bus_in,
   input wire logic [7:0] dev_dout,
   input wire logic dev_oe
);
   logic drv_en;
   logic [7:0] drv;
   logic [7:0] last;
   initial begin
      sel_n = 3'h7;
      addr = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      drv_en = 1'b0;
      drv = 8'h00;
      last = 8'h00;
   end
   always_comb begin
      if (dev_oe) bus_in = dev_dout;
      else if (drv_en) bus_in = drv;
      else bus_in = ~last;
   end
   always @(posedge clk) last <= bus_in;
   // callers pass one low select or none, never several
   task automatic xfer(input logic [2:0] s, input logic a, input logic wr,
         input logic [7:0] d, output logic [7:0] q, output logic ok);
      int i;
      q = 8'h00;
      ok = wr;
      @(posedge clk);
      sel_n <= s;
      addr <= a;
      drv <= d;
      drv_en <= wr;
      @(posedge clk);
      if (wr) wr_n <= 1'b0;
      else rd_n <= 1'b0;
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         #1;
         if (!wr && dev_oe && !ok) begin
            q = dev_dout;
            ok = 1'b1;
         end
      end
      @(posedge clk);
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      @(posedge clk);
      sel_n <= 3'h7;
      drv_en <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ### testbench/host_mailbox_ports_test.sv
// Purpose: self-checking bench of the three host mailbox ports
// Assumes: controller strobes are one clock wide
// Notes: port 0 keyboard, 1 and 2 power ports
`timescale 1ns/10ps
`default_nettype none
module host_mailbox_ports_test;
   localparam logic [2:0] SEL [3] = '{3'h6, 3'h5, 3'h3};
   logic clk, resetn, addr, rd_n, wr_n, oe, s_wr, s_rd, ok;
   logic kirq, p1n, p2n;
   logic [2:0] sel_n, ien, in_irq, hirq;
   logic [7:0] bus_in, dout, s_a, s_wd, s_rd_d, q;
   int err_total, n_checks, p;
   assign hirq = {p2n, p1n, kirq};
   hmp_ports dut_u (.clk(clk), .resetn(resetn),
      .kbd_port_select_n(sel_n[0]), .power_port_one_select_n(sel_n[1]),
      .power_port_two_select_n(sel_n[2]), .host_addr_bit(addr),
      .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
      .host_data_in(bus_in), .host_data_out(dout), .host_data_oe(oe),
      .sfr_addr(s_a), .sfr_wr_en(s_wr), .sfr_rd_en(s_rd),
      .sfr_wdata(s_wd), .sfr_rdata(s_rd_d),
      .kbd_in_irq_enable(ien[0]), .power_one_in_irq_enable(ien[1]),
      .power_two_in_irq_enable(ien[2]), .kbd_in_irq(in_irq[0]),
      .power_one_in_irq(in_irq[1]), .power_two_in_irq(in_irq[2]),
      .kbd_host_irq(kirq), .power_one_host_irq_n(p1n),
      .power_two_host_irq_n(p2n));
   hmp_host_model host_u (.clk(clk), .sel_n(sel_n), .addr(addr),
      .rd_n(rd_n), .wr_n(wr_n), .bus_in(bus_in), .dev_dout(dout),
      .dev_oe(oe));
   initial clk = 1'b0;
   always #20 clk = ~clk;
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen,
         input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      s_a <= a;
      s_wd <= d;
      s_wr <= 1'b1;
      @(posedge clk);
      s_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      s_a <= a;
      s_rd <= 1'b1;
      @(posedge clk);
      s_rd <= 1'b0;
      @(posedge clk);
      #1 d = s_rd_d;
   endtask
   // host cycle; a read that never drives the bus ends the run
   task automatic hx(input logic [2:0] s, input logic a, input logic wr,
         input logic [7:0] d);
      host_u.xfer(s, a, wr, d, q, ok);
      check("host cycle", {7'h0, ok}, 8'h01);
      if (ok !== 1'b1) begin
         summarize();
      end
   endtask
   initial begin
      resetn = 1'b0;
      s_a = 8'h00;
      s_wd = 8'h00;
      s_wr = 1'b0;
      s_rd = 1'b0;
      ien = 3'h7;
      err_total = 0;
      n_checks = 0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (8) @(posedge clk);
      check("host irq idle", {5'h0, hirq}, 8'h06);
      for (p = 0; p < 3; p++) begin
         reg_rd(hmp_pkg::STATUS_OFS[p], q);
         check("flags", q & 8'h03, 8'h00);
         reg_wr(hmp_pkg::OUTPUT_OFS[p], 8'h5a + 8'(p));
         repeat (2) @(posedge clk);
         check("host irq", {5'h0, hirq}, {5'h0, 3'h6 ^ (3'h1 << p)});
         reg_rd(hmp_pkg::STATUS_OFS[p], q);
         check("out full", q & 8'h03, 8'h01);
         reg_rd(hmp_pkg::OUTPUT_OFS[p], q);
         check("out reg", q, 8'h5a + 8'(p));
         hx(SEL[p], 1'b0, 1'b0, 8'h00);
         check("host data", q, 8'h5a + 8'(p));
         check("host irq off", {5'h0, hirq}, 8'h06);
         reg_rd(hmp_pkg::STATUS_OFS[p], q);
         check("out empty", q & 8'h01, 8'h00);
         hx(SEL[p], 1'b1, 1'b1, 8'hc0 + 8'(p));
         // earlier ports keep their input-full from the last host write
         check("in irq", {5'h0, in_irq}, 8'((2 << p) - 1));
         reg_wr(hmp_pkg::INPUT_OFS[p], 8'h33);
         reg_rd(hmp_pkg::STATUS_OFS[p], q);
         check("cmd in full", q & 8'h0b, 8'h0a);
         reg_rd(hmp_pkg::INPUT_OFS[p], q);
         check("in data", q, 8'hc0 + 8'(p));
         reg_rd(hmp_pkg::STATUS_OFS[p], q);
         check("in cleared", q & 8'h02, 8'h00);
         check("in irq off", {5'h0, in_irq}, 8'((1 << p) - 1));
         hx(SEL[p], 1'b0, 1'b1, 8'h10 + 8'(p));
         reg_wr(hmp_pkg::STATUS_OFS[p], 8'hff);
         reg_rd(hmp_pkg::STATUS_OFS[p], q);
         check("user bits", q, 8'hf6);
         hx(SEL[p], 1'b1, 1'b0, 8'h00);
         check("host status", q, 8'hf6);
      end
      @(posedge clk);
      ien <= 3'h0;
      repeat (2) @(posedge clk);
      #1 check("masked irq", {5'h0, in_irq}, 8'h00);
      @(posedge clk);
      ien <= 3'h7;
      repeat (2) @(posedge clk);
      #1 check("enabled irq", {5'h0, in_irq}, 8'h07);
      reg_rd(8'h00, q);
      check("unmapped", q, 8'hf6);
      hx(3'h7, 1'b1, 1'b1, 8'h99);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (4) @(posedge clk);
      check("irq in reset", {2'h0, hirq, in_irq}, 8'h30);
      resetn <= 1'b1;
      repeat (8) @(posedge clk);
      for (p = 0; p < 3; p++) begin
         reg_rd(hmp_pkg::STATUS_OFS[p], q);
         check("status kept", q, 8'hf4);
         reg_rd(hmp_pkg::INPUT_OFS[p], q);
         check("input kept", q, 8'h10 + 8'(p));
      end
      summarize();
   end
endmodule
`default_nettype wire
